// ===== core/spsc_pkg.sv
// Shared constants and types of the system PLL status and calibration block
package spsc_pkg;
    // Register addresses
    localparam logic [15:0] SPSC_ADDR_UPDATE = 16'h000f;
    localparam logic [15:0] SPSC_ADDR_HOLDOFF_0 = 16'h0207;
    localparam logic [15:0] SPSC_ADDR_HOLDOFF_1 = 16'h0208;
    localparam logic [15:0] SPSC_ADDR_HOLDOFF_2 = 16'h0209;
    localparam logic [15:0] SPSC_ADDR_COMP = 16'h020a;
    localparam logic [15:0] SPSC_ADDR_CTRL = 16'h2000;
    localparam logic [15:0] SPSC_ADDR_STATUS = 16'h3001;
    localparam logic [15:0] SPSC_ADDR_IRQ_STAT = 16'h3100;
    localparam logic [15:0] SPSC_ADDR_IRQ_MASK = 16'h3101;
    // Field positions
    localparam int SPSC_UPDATE_BIT = 0;
    localparam int SPSC_CTRL_PD_BIT = 0;
    localparam int SPSC_CTRL_CAL_BIT = 2;
    localparam int SPSC_STAT_LOCK_BIT = 0;
    localparam int SPSC_STAT_STABLE_BIT = 1;
    localparam int SPSC_STAT_BUSY_BIT = 2;
    localparam int SPSC_COMP_EN_BIT = 0;
    localparam int SPSC_COMP_SRC_BIT = 1;
    localparam int SPSC_IRQ_LOCK_UP = 0;
    localparam int SPSC_IRQ_LOCK_DN = 1;
    localparam int SPSC_IRQ_STABLE_UP = 2;
    localparam int SPSC_IRQ_STABLE_DN = 3;
    localparam int SPSC_IRQ_CAL_DONE = 4;
    localparam int SPSC_IRQ_W = 5;
    localparam int SPSC_HOLDOFF_W = 20;
    // Writable bits and reset values
    localparam logic [7:0] SPSC_CTRL_MASK = 8'h05;
    localparam logic [7:0] SPSC_COMP_MASK = 8'h03;
    localparam logic [19:0] SPSC_HOLDOFF_RST = 20'h00000;
    localparam logic [7:0] SPSC_CTRL_RST = 8'h00;
    localparam logic [7:0] SPSC_COMP_RST = 8'h00;
    localparam logic [4:0] SPSC_IRQ_MASK_RST = 5'h00;
    // Timing
    localparam int SPSC_CLK_PERIOD_NS = 10;
    localparam int SPSC_MS_TIME_NS = 1000000;
    localparam int SPSC_MS_CYCLES = SPSC_MS_TIME_NS / SPSC_CLK_PERIOD_NS;
    localparam int SPSC_CAL_TIME_NS = 20000;
    localparam int SPSC_CAL_CYCLES = SPSC_CAL_TIME_NS / SPSC_CLK_PERIOD_NS;
    localparam int SPSC_LOCK_WIN_NS = 50;
    localparam int SPSC_LOCK_WIN_CYCLES = SPSC_LOCK_WIN_NS / SPSC_CLK_PERIOD_NS;
    localparam int SPSC_LOCK_GOOD_COUNT = 4;

    typedef enum logic [1:0] {
        SPSC_CAL_IDLE = 2'b01,
        SPSC_CAL_RUN = 2'b10
    } spsc_cal_state_type;
endpackage

// ===== core/spsc_lock_detect.sv
// Edge-offset lock detector comparing reference and feedback edges
`timescale 1ns/100ps
module spsc_lock_detect
    import spsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic ref_edge,
    input wire logic fb_edge,
    output logic locked
);
    localparam logic [3:0] WIN = 4'(SPSC_LOCK_WIN_CYCLES);
    localparam logic [2:0] GOOD_LAST = 3'(SPSC_LOCK_GOOD_COUNT - 1);

    logic open_reg, open_next;
    logic owner_ref_reg, owner_ref_next;
    logic [3:0] age_reg, age_next;
    logic [2:0] good_reg, good_next;
    logic locked_reg, locked_next;
    logic pair_good, pair_bad;

    always_comb begin
        open_next = open_reg;
        owner_ref_next = owner_ref_reg;
        age_next = open_reg ? age_reg + 4'h1 : age_reg;
        pair_good = 1'b0;
        pair_bad = 1'b0;
        if (!open_reg) begin
            if (ref_edge && fb_edge) begin
                pair_good = 1'b1;
            end else if (ref_edge || fb_edge) begin
                open_next = 1'b1;
                owner_ref_next = ref_edge;
                age_next = 4'h0;
            end
        end else if (owner_ref_reg ? fb_edge : ref_edge) begin
            pair_good = 1'b1; // R1
            open_next = 1'b0;
        end else if (owner_ref_reg ? ref_edge : fb_edge) begin
            // Two edges of one kind with none of the other: offset too large
            pair_bad = 1'b1; // R1
            age_next = 4'h0;
        end else if (age_reg == WIN) begin
            pair_bad = 1'b1; // R1
            open_next = 1'b0;
        end
        if (pair_bad) begin
            good_next = 3'h0;
        end else if (pair_good && good_reg != GOOD_LAST) begin
            good_next = good_reg + 3'h1;
        end else begin
            good_next = good_reg;
        end
        locked_next = !pair_bad && (locked_reg || (pair_good && good_reg == GOOD_LAST));
        if (!enable) begin
            open_next = 1'b0;
            age_next = 4'h0;
            good_next = 3'h0;
            locked_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            open_reg <= 1'b0;
            owner_ref_reg <= 1'b0;
            age_reg <= 4'h0;
            good_reg <= 3'h0;
            locked_reg <= 1'b0;
        end else begin
            open_reg <= open_next;
            owner_ref_reg <= owner_ref_next;
            age_reg <= age_next;
            good_reg <= good_next;
            locked_reg <= locked_next;
        end
    end

    assign locked = locked_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_bad_unlocks;
        pair_bad |=> !locked;
    endproperty
    a_bad_unlocks: assert property (p_bad_unlocks) else $error("lock kept after bad edge pair"); // R1

    property p_lock_needs_pair;
        $rose(locked) |-> $past(pair_good) && $past(enable);
    endproperty
    a_lock_needs_pair: assert property (p_lock_needs_pair) else $error("lock without good pair"); // R1
endmodule

// ===== core/spsc_stab_timer.sv
// Millisecond hold-off timer that qualifies lock into a stable indication
`timescale 1ns/100ps
module spsc_stab_timer
    import spsc_pkg::*;
#(
    parameter int MS_CYC = SPSC_MS_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic locked,
    input wire logic [19:0] holdoff,
    output logic stable
);
    localparam logic [31:0] PRE_LAST = 32'(MS_CYC - 1);

    logic [31:0] pre_reg, pre_next;
    logic [19:0] ms_reg, ms_next;
    logic stable_reg, stable_next;

    always_comb begin
        pre_next = pre_reg;
        ms_next = ms_reg;
        if (!locked) begin
            // Any loss of lock restarts the hold-off from zero
            pre_next = 32'h0; // R16
            ms_next = 20'h0; // R16
        end else if (pre_reg == PRE_LAST) begin
            pre_next = 32'h0;
            if (ms_reg != 20'hfffff) begin
                ms_next = ms_reg + 20'h1;
            end
        end else begin
            pre_next = pre_reg + 32'h1;
        end
        // Zero hold-off forces unstable; all-ones is left to software to avoid
        stable_next = locked && holdoff != 20'h0 && ms_reg >= holdoff; // R4 R5 R16
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_reg <= 32'h0;
            ms_reg <= 20'h0;
            stable_reg <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            ms_reg <= ms_next;
            stable_reg <= stable_next;
        end
    end

    assign stable = stable_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_holdoff_met;
        stable |-> $past(locked) && $past(ms_reg) >= $past(holdoff);
    endproperty
    a_holdoff_met: assert property (p_holdoff_met) else $error("stable before hold-off"); // R4

    property p_zero_unstable;
        holdoff == 20'h0 |=> !stable;
    endproperty
    a_zero_unstable: assert property (p_zero_unstable) else $error("stable with zero hold-off"); // R5

    property p_restart;
        $rose(locked) |-> ms_reg == 20'h0 && pre_reg == 32'h0 ##1 !stable;
    endproperty
    a_restart: assert property (p_restart) else $error("hold-off not restarted"); // R16
endmodule

// ===== core/spsc_core.sv
// System PLL lock, stability and VCO calibration control with register port
// What this block does
// R1 - Lock is judged from the offset between reference and feedback edges.
// R2 - Lock flag reads at bit 0 of status register 0x3001.
// R3 - From power-up until configured and locked, clock reports unstable.
// R4 - Stable only after lock persists for the 20-bit millisecond hold-off.
// R5 - Hold-off of zero forces unstable regardless of lock.
// R6 - Software must never program the hold-off to all ones.
// R7 - Stable flag reads at bit 1 of status register 0x3001.
// R8 - Clock status also goes straight to internal timekeeping blocks.
// R9 - Power-up runs a VCO calibration without any software request.
// R10 - Software requests calibration via control bit 2 after VCO changes.
// R11 - Calibration bit never self-clears; write one, update, zero, update.
// R12 - Busy flag at status bit 2 is high while calibrating.
// R13 - Leaving any power-down needs no system PLL recalibration.
// R14 - After clock power-down, software recalibrates the output analog PLLs.
// R15 - Compensation from a stable source loop applies to the other loop.
// R16 - Stable drops on lock loss; hold-off restarts on next lock.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module spsc_core
    import spsc_pkg::*;
#(
    parameter int MS_CYC = SPSC_MS_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic ref_edge,
    input wire logic fb_edge,
    input wire logic comp_source_valid,
    output logic vco_cal_run,
    output logic sys_pll_power_down,
    output logic sys_clock_stable,
    output logic [1:0] comp_apply_loop,
    output logic irq
);
    localparam logic [11:0] CAL_LAST = 12'(SPSC_CAL_CYCLES - 1);

    // Staged and committed copies of the hold-off, control and compensation registers
    logic [19:0] holdoff_sh_reg, holdoff_sh_next;
    logic [7:0] ctrl_sh_reg, ctrl_sh_next;
    logic [7:0] comp_sh_reg, comp_sh_next;
    logic [19:0] holdoff_reg, holdoff_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] comp_reg, comp_next;
    logic [4:0] irq_mask_reg, irq_mask_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [4:0] irq_stat_reg, irq_stat_next;
    logic lock_d_reg, stable_d_reg;
    logic [1:0] comp_apply_reg, comp_apply_next;
    spsc_cal_state_type cal_state_reg, cal_state_next;
    logic [11:0] cal_cnt_reg, cal_cnt_next;

    logic commit;
    logic cal_trig;
    logic cal_done;
    logic cal_busy;
    logic lock;
    logic stable;
    logic lock_enable;
    logic [4:0] irq_event;
    logic [4:0] irq_clear;
    logic [7:0] status_word;

    assign commit = reg_wr && reg_addr == SPSC_ADDR_UPDATE && reg_wdata[SPSC_UPDATE_BIT];
    // A new request is a committed 0-to-1 of the calibration bit
    assign cal_trig = commit && ctrl_sh_reg[SPSC_CTRL_CAL_BIT]
        && !ctrl_reg[SPSC_CTRL_CAL_BIT]; // R10 R11
    assign cal_busy = cal_state_reg == SPSC_CAL_RUN;
    // Lock is not trusted while the VCO is retuned or the PLL is off
    assign lock_enable = !cal_busy && !ctrl_reg[SPSC_CTRL_PD_BIT]; // R3
    assign status_word = {5'h00, cal_busy, stable, lock}; // R2 R7 R12

    spsc_lock_detect u_lock (
        .clk(clk),
        .rst(rst),
        .enable(lock_enable),
        .ref_edge(ref_edge),
        .fb_edge(fb_edge),
        .locked(lock)
    );

    spsc_stab_timer #(
        .MS_CYC(MS_CYC)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .locked(lock),
        .holdoff(holdoff_reg),
        .stable(stable)
    );

    // Register file
    always_comb begin
        holdoff_sh_next = holdoff_sh_reg;
        ctrl_sh_next = ctrl_sh_reg;
        comp_sh_next = comp_sh_reg;
        irq_mask_next = irq_mask_reg;
        rdata_next = 8'h00;
        if (reg_wr) begin
            unique case (reg_addr)
                SPSC_ADDR_HOLDOFF_0: holdoff_sh_next[7:0] = reg_wdata;
                SPSC_ADDR_HOLDOFF_1: holdoff_sh_next[15:8] = reg_wdata;
                SPSC_ADDR_HOLDOFF_2: holdoff_sh_next[19:16] = reg_wdata[3:0];
                SPSC_ADDR_CTRL: ctrl_sh_next = reg_wdata & SPSC_CTRL_MASK;
                SPSC_ADDR_COMP: comp_sh_next = reg_wdata & SPSC_COMP_MASK;
                SPSC_ADDR_IRQ_MASK: irq_mask_next = reg_wdata[4:0];
                default: irq_mask_next = irq_mask_reg;
            endcase
        end
        // Hold-off, control and compensation writes take effect only when committed by the update strobe
        holdoff_next = commit ? holdoff_sh_reg : holdoff_reg; // R4
        ctrl_next = commit ? ctrl_sh_reg : ctrl_reg; // R11
        comp_next = commit ? comp_sh_reg : comp_reg;
        if (reg_rd) begin
            unique case (reg_addr)
                SPSC_ADDR_HOLDOFF_0: rdata_next = holdoff_reg[7:0];
                SPSC_ADDR_HOLDOFF_1: rdata_next = holdoff_reg[15:8];
                SPSC_ADDR_HOLDOFF_2: rdata_next = {4'h0, holdoff_reg[19:16]};
                SPSC_ADDR_CTRL: rdata_next = ctrl_reg;
                SPSC_ADDR_COMP: rdata_next = comp_reg;
                SPSC_ADDR_STATUS: rdata_next = status_word; // R2 R7 R12
                SPSC_ADDR_IRQ_STAT: rdata_next = {3'h0, irq_stat_reg};
                SPSC_ADDR_IRQ_MASK: rdata_next = {3'h0, irq_mask_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            holdoff_sh_reg <= SPSC_HOLDOFF_RST;
            ctrl_sh_reg <= SPSC_CTRL_RST;
            comp_sh_reg <= SPSC_COMP_RST;
            holdoff_reg <= SPSC_HOLDOFF_RST;
            ctrl_reg <= SPSC_CTRL_RST;
            comp_reg <= SPSC_COMP_RST;
            irq_mask_reg <= SPSC_IRQ_MASK_RST;
            rdata_reg <= 8'h00;
        end else begin
            holdoff_sh_reg <= holdoff_sh_next;
            ctrl_sh_reg <= ctrl_sh_next;
            comp_sh_reg <= comp_sh_next;
            holdoff_reg <= holdoff_next;
            ctrl_reg <= ctrl_next;
            comp_reg <= comp_next;
            irq_mask_reg <= irq_mask_next;
            rdata_reg <= rdata_next;
        end
    end

    // Calibration sequencer; reset enters the run state so power-up calibrates
    always_comb begin
        cal_state_next = cal_state_reg;
        cal_cnt_next = cal_cnt_reg;
        cal_done = 1'b0;
        unique case (cal_state_reg)
            SPSC_CAL_IDLE: begin
                if (cal_trig) begin
                    cal_state_next = SPSC_CAL_RUN; // R10
                    cal_cnt_next = 12'h000;
                end
            end
            SPSC_CAL_RUN: begin
                if (cal_trig) begin
                    // New parameters mid-run: start over rather than finish stale
                    cal_cnt_next = 12'h000;
                end else if (cal_cnt_reg == CAL_LAST) begin
                    cal_state_next = SPSC_CAL_IDLE;
                    cal_done = 1'b1;
                end else begin
                    cal_cnt_next = cal_cnt_reg + 12'h001;
                end
            end
            default: begin
                cal_state_next = SPSC_CAL_RUN;
                cal_cnt_next = 12'h000;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cal_state_reg <= SPSC_CAL_RUN; // R9
            cal_cnt_reg <= 12'h000;
        end else begin
            cal_state_reg <= cal_state_next;
            cal_cnt_reg <= cal_cnt_next;
        end
    end

    // Events, interrupt status and compensation steering
    always_comb begin
        irq_event = 5'h00;
        irq_event[SPSC_IRQ_LOCK_UP] = lock && !lock_d_reg;
        irq_event[SPSC_IRQ_LOCK_DN] = !lock && lock_d_reg;
        irq_event[SPSC_IRQ_STABLE_UP] = stable && !stable_d_reg;
        irq_event[SPSC_IRQ_STABLE_DN] = !stable && stable_d_reg;
        irq_event[SPSC_IRQ_CAL_DONE] = cal_done;
        irq_clear = (reg_wr && reg_addr == SPSC_ADDR_IRQ_STAT) ? reg_wdata[4:0] : 5'h00;
        // Set wins over a clear in the same cycle
        irq_stat_next = (irq_stat_reg & ~irq_clear) | irq_event;
        comp_apply_next = 2'b00;
        if (comp_reg[SPSC_COMP_EN_BIT] && comp_source_valid && stable) begin
            // The loop holding the stable source corrects the other one
            comp_apply_next = comp_reg[SPSC_COMP_SRC_BIT] ? 2'b01 : 2'b10; // R15
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_reg <= 5'h00;
            lock_d_reg <= 1'b0;
            stable_d_reg <= 1'b0;
            comp_apply_reg <= 2'b00;
        end else begin
            irq_stat_reg <= irq_stat_next;
            lock_d_reg <= lock;
            stable_d_reg <= stable;
            comp_apply_reg <= comp_apply_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign vco_cal_run = cal_busy;
    // Power-down restore has no path into the sequencer
    assign sys_pll_power_down = ctrl_reg[SPSC_CTRL_PD_BIT]; // R13
    assign sys_clock_stable = stable; // R8
    assign comp_apply_loop = comp_apply_reg;
    assign irq = |(irq_stat_reg & irq_mask_reg);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_cal_last;
        cal_busy && cal_cnt_reg == CAL_LAST && !cal_trig;
    endsequence
    sequence s_cal_over;
        !cal_busy && irq_stat_reg[SPSC_IRQ_CAL_DONE];
    endsequence

    property p_lock_bit;
        reg_rd && reg_addr == SPSC_ADDR_STATUS |=> reg_rdata[0] == $past(lock);
    endproperty
    a_lock_bit: assert property (p_lock_bit) else $error("status lock bit wrong"); // R2

    property p_stable_bit;
        reg_rd && reg_addr == SPSC_ADDR_STATUS |=> reg_rdata[1] == $past(stable);
    endproperty
    a_stable_bit: assert property (p_stable_bit) else $error("status stable bit wrong"); // R7

    property p_busy_bit;
        reg_rd && reg_addr == SPSC_ADDR_STATUS |=> reg_rdata[2] == $past(cal_busy);
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("status busy bit wrong"); // R12

    property p_powerup_cal;
        $fell(rst) |-> cal_busy && cal_cnt_reg == 12'h000;
    endproperty
    a_powerup_cal: assert property (p_powerup_cal) else $error("no calibration at power-up"); // R9

    property p_manual_cal;
        cal_trig |=> cal_busy && cal_cnt_reg == 12'h000 ##1 cal_busy;
    endproperty
    a_manual_cal: assert property (p_manual_cal) else $error("request did not start calibration"); // R11

    property p_cal_end;
        s_cal_last |=> s_cal_over;
    endproperty
    a_cal_end: assert property (p_cal_end) else $error("calibration did not end on time"); // R12

    property p_unstable_cal;
        cal_busy |-> ##2 !sys_clock_stable;
    endproperty
    a_unstable_cal: assert property (p_unstable_cal) else $error("stable during calibration"); // R3

    property p_no_recal;
        $fell(ctrl_reg[SPSC_CTRL_PD_BIT]) && !cal_busy && !cal_trig |=> !cal_busy;
    endproperty
    a_no_recal: assert property (p_no_recal) else $error("recalibrated after power-down"); // R13

    property p_comp;
        comp_apply_loop != 2'b00 |-> $past(sys_clock_stable) && $past(comp_reg[SPSC_COMP_EN_BIT]);
    endproperty
    a_comp: assert property (p_comp) else $error("compensation without stable clock"); // R15
endmodule

// ===== test/spsc_core_tb.sv
// Self-checking testbench of the system PLL status and calibration block
`timescale 1ns/100ps
module spsc_core_tb
    import spsc_pkg::*;
;
    localparam int MS = 10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic ref_edge = 1'b0;
    logic fb_edge = 1'b0;
    logic comp_source_valid = 1'b0;
    logic vco_cal_run;
    logic sys_pll_power_down;
    logic sys_clock_stable;
    logic [1:0] comp_apply_loop;
    logic irq;
    logic [1:0] edge_mode = 2'h0;
    logic [3:0] edge_cnt = 4'h0;
    int n_mismatch = 0;
    int n_tests = 0;

    spsc_core #(.MS_CYC(MS)) i_dut (
        .clk(clk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .ref_edge(ref_edge),
        .fb_edge(fb_edge),
        .comp_source_valid(comp_source_valid),
        .vco_cal_run(vco_cal_run),
        .sys_pll_power_down(sys_pll_power_down),
        .sys_clock_stable(sys_clock_stable),
        .comp_apply_loop(comp_apply_loop),
        .irq(irq)
    );

    always #5 clk = ~clk;

    // Mode 1 gives coincident pairs, mode 2 gives lone reference edges that break lock
    always @(posedge clk) begin
        edge_cnt <= edge_cnt + 4'h1;
        ref_edge <= (edge_mode != 2'h0) && (edge_cnt[2:0] == 3'h0);
        fb_edge <= (edge_mode == 2'h1) && (edge_cnt[2:0] == 3'h0);
    end

    task automatic finish_test();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Staged write followed by the commit strobe
    task automatic wr_upd(input logic [15:0] a, input logic [7:0] d);
        wr(a, d);
        wr(SPSC_ADDR_UPDATE, 8'h01);
    endtask

    task automatic rdc(input string name, input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(name, exp, reg_rdata);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic get(input int idx);
        case (idx)
            0: return vco_cal_run;
            1: return sys_clock_stable;
            default: return irq;
        endcase
    endfunction

    // Bounded wait; running out counts as a mismatch and closes the run
    task automatic wait_sig(input int idx, input logic val, input int max);
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < max && !ok; i++) begin
            @(posedge clk);
            #1;
            ok = (get(idx) === val);
        end
        if (!ok) begin
            $display("Error %s expected %b seen %b",
                idx == 0 ? "vco_cal_run" : (idx == 1 ? "sys_clock_stable" : "irq"), val, get(idx));
            n_mismatch++;
            finish_test();
        end
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        check("vco_cal_run", 8'h01, {7'h00, vco_cal_run});
        rdc("status", SPSC_ADDR_STATUS, 8'h04);
        rdc("unmapped", 16'h1234, 8'h00);
        wait_sig(0, 1'b0, 2100);
        rdc("irq_status", SPSC_ADDR_IRQ_STAT, 8'h10);
        check("irq", 8'h00, {7'h00, irq});
        wr(SPSC_ADDR_IRQ_MASK, 8'h10);
        cyc(1);
        check("irq", 8'h01, {7'h00, irq});
        wr(SPSC_ADDR_IRQ_STAT, 8'h10);
        cyc(1);
        check("irq", 8'h00, {7'h00, irq});
        wr(SPSC_ADDR_IRQ_MASK, 8'h00);
        // Lock with hold-off still zero: stable must stay low
        edge_mode <= 2'h1;
        cyc(60);
        rdc("status", SPSC_ADDR_STATUS, 8'h01);
        cyc(60);
        check("sys_clock_stable", 8'h00, {7'h00, sys_clock_stable});
        wr(SPSC_ADDR_HOLDOFF_0, 8'h02);
        wr(SPSC_ADDR_HOLDOFF_1, 8'h00);
        wr(SPSC_ADDR_HOLDOFF_2, 8'h00);
        rdc("holdoff_0", SPSC_ADDR_HOLDOFF_0, 8'h00);
        edge_mode <= 2'h2;
        wr(SPSC_ADDR_UPDATE, 8'h01);
        rdc("holdoff_0", SPSC_ADDR_HOLDOFF_0, 8'h02);
        cyc(40);
        rdc("status", SPSC_ADDR_STATUS, 8'h00);
        // Relock: stable may not rise before the full hold-off has run from zero
        edge_mode <= 2'h1;
        for (int i = 0; i < 2 * MS + 26; i++) begin
            cyc(1);
            check("sys_clock_stable", 8'h00, {7'h00, sys_clock_stable});
        end
        wait_sig(1, 1'b1, 40);
        rdc("status", SPSC_ADDR_STATUS, 8'h03);
        @(posedge clk);
        comp_source_valid <= 1'b1;
        wr_upd(SPSC_ADDR_COMP, 8'h01);
        cyc(3);
        check("comp_apply_loop", 8'h02, {6'h00, comp_apply_loop});
        wr_upd(SPSC_ADDR_COMP, 8'h03);
        cyc(3);
        check("comp_apply_loop", 8'h01, {6'h00, comp_apply_loop});
        @(posedge clk);
        comp_source_valid <= 1'b0;
        cyc(3);
        check("comp_apply_loop", 8'h00, {6'h00, comp_apply_loop});
        // Manual calibration, then the clearing half of the sequence
        wr_upd(SPSC_ADDR_CTRL, 8'h04);
        cyc(2);
        check("vco_cal_run", 8'h01, {7'h00, vco_cal_run});
        rdc("status", SPSC_ADDR_STATUS, 8'h04);
        // Busy began at the commit edge, four edges ago; it must last exactly the run time
        cyc(SPSC_CAL_CYCLES - 5);
        check("vco_cal_run", 8'h01, {7'h00, vco_cal_run});
        wait_sig(0, 1'b0, 1);
        rdc("ctrl", SPSC_ADDR_CTRL, 8'h04);
        wr_upd(SPSC_ADDR_CTRL, 8'h00);
        cyc(3);
        check("vco_cal_run", 8'h00, {7'h00, vco_cal_run});
        rdc("ctrl", SPSC_ADDR_CTRL, 8'h00);
        // Power-down and restore must not start a calibration
        wr_upd(SPSC_ADDR_CTRL, 8'h01);
        cyc(3);
        check("sys_pll_power_down", 8'h01, {7'h00, sys_pll_power_down});
        check("sys_clock_stable", 8'h00, {7'h00, sys_clock_stable});
        wr_upd(SPSC_ADDR_CTRL, 8'h00);
        cyc(3);
        // Clock restored: recalibrating the output analog PLLs is left to software
        check("sys_pll_power_down", 8'h00, {7'h00, sys_pll_power_down});
        check("vco_cal_run", 8'h00, {7'h00, vco_cal_run});
        finish_test();
    end
endmodule
